// ### core/level_width_check.v
// Purpose: Checks requested level and execution width for legality
// Assumes: Inputs synchronous to i_clk_sys
// Notes:   Combinational; registered in the top module
`timescale 1ns/1ps
`include "security_state_map.vh"

module level_width_check #(
  parameter ALLOW_NARROW_EL0 = 1
) (
  // Request
  input  wire [1:0] i_level,
  input  wire       i_narrow,
  // Verdict
  output wire       o_width_bad
);

  // narrow width only at level zero
  assign o_width_bad = i_narrow &
                       ((i_level != `LEVEL_ZERO) | (ALLOW_NARROW_EL0 == 0));

endmodule // level_width_check

// ### core/security_state_decode.v
// Behaviour
// - Four privilege levels zero to three; three is the most privileged.
// - Thirty-two-bit execution only optional at level zero, never at one to three.
// - Four security states decoded: Non-secure, Secure, Realm, Root.
// - Level three always reports Root regardless of configuration bits.
// - Below level three: 00 Secure, 01 Non-secure, 11 Realm, 10 reserved.
// - Return from level three to a lower level with reserved bits is an illegal return.
//
// Purpose: Decodes current security state and checks exception returns
// Assumes: All inputs synchronous to i_clk_sys; return request is a pulse
// Notes:   Outputs registered, one cycle after inputs
//          Return verdict and landing state hold until the next return
//          Reserved pair decodes as Secure while it is flagged
//          Narrow width legal only at level zero
`timescale 1ns/1ps
`include "security_state_map.vh"

module security_state_decode #(
  parameter ALLOW_NARROW_EL0 = 1
) (
  // Clock and reset
  input  wire       i_clk_sys,
  input  wire       i_rst,
  // Current state
  input  wire [1:0] i_cur_level,
  input  wire       i_ext_nonsecure_bit,
  input  wire       i_nonsecure_bit,
  input  wire       i_realm_feature_flag,
  // Exception return request
  input  wire       i_ret_valid,
  input  wire [1:0] i_ret_level,
  input  wire       i_ret_narrow,
  // Decoded state
  output reg  [1:0] o_sec_state,
  output reg        o_reserved_enc,
  output reg        o_cur_width_bad,
  // Exception return verdict
  output reg        o_ret_done,
  output reg        o_ret_illegal,
  output reg  [1:0] o_ret_sec_state
);

  // Number of privilege levels and their codes, lowest first
  localparam       LEVELS      = 4;
  localparam [7:0] LEVEL_CODES = {`LEVEL_TOP, `LEVEL_TWO, `LEVEL_ONE, `LEVEL_ZERO};

  // Current state next value
  reg  [1:0] sec_nxt;
  wire       rsvd;
  wire [1:0] low_pair_state;

  // Return next values
  reg  [1:0] ret_sec_nxt;
  reg        ret_illegal_nxt;
  wire       ret_from_top;

  // Landing state, width fault and verdict per target level
  wire [7:0] land_state;
  wire [3:0] land_width_bad;
  wire [3:0] land_illegal;

  assign rsvd = i_realm_feature_flag ? (i_ext_nonsecure_bit & ~i_nonsecure_bit)
                                     : 1'b0;

  // Return leaves the top level
  assign ret_from_top = (i_cur_level == `LEVEL_TOP);

  // Lower state decode for a level below three
  function [1:0] low_state;
    input ext_b;
    input ns_b;
    input feat;
    begin
      case ({ext_b & feat, ns_b})
        2'h0:    low_state = `SEC_SECURE;
        2'h1:    low_state = `SEC_NONSECURE;
        2'h3:    low_state = `SEC_REALM;
        default: low_state = `SEC_SECURE; // Reserved; flagged separately
      endcase
    end
  endfunction

  // state of any level below three
  assign low_pair_state = low_state(i_ext_nonsecure_bit, i_nonsecure_bit,
                                    i_realm_feature_flag);

  // one table entry for each of the four levels
  genvar lv;
  generate
    for (lv = 0; lv < LEVELS; lv = lv + 1) begin : g_level
      // width legality at this target level
      level_width_check #(
        .ALLOW_NARROW_EL0 (ALLOW_NARROW_EL0)
      ) u_chk (
        .i_level     (LEVEL_CODES[2*lv+1:2*lv]),
        .i_narrow    (i_ret_narrow),
        .o_width_bad (land_width_bad[lv])
      );

      // Entry contents by level
      if (lv == LEVELS - 1) begin : g_top
        // level three is Root whatever the bits
        assign land_state[2*lv+1:2*lv] = `SEC_ROOT;
        // Return to three skips the reserved check
        assign land_illegal[lv]        = land_width_bad[lv];
      end else begin : g_low
        assign land_state[2*lv+1:2*lv] = low_pair_state;
        // reserved bits on return from three
        assign land_illegal[lv]        = land_width_bad[lv] | (ret_from_top & rsvd);
      end
    end
  endgenerate

  // current state from the level table
  always @* begin
    case (i_cur_level)
      `LEVEL_ZERO: begin
        sec_nxt = land_state[1:0];
      end
      `LEVEL_ONE: begin
        sec_nxt = land_state[3:2];
      end
      `LEVEL_TWO: begin
        sec_nxt = land_state[5:4];
      end
      default: begin
        sec_nxt = land_state[7:6];
      end
    endcase
  end

  // Landing entry of the requested target level
  always @* begin
    case (i_ret_level)
      `LEVEL_ZERO: begin
        ret_sec_nxt     = land_state[1:0];
        ret_illegal_nxt = land_illegal[0];
      end
      `LEVEL_ONE: begin
        ret_sec_nxt     = land_state[3:2];
        ret_illegal_nxt = land_illegal[1];
      end
      `LEVEL_TWO: begin
        ret_sec_nxt     = land_state[5:4];
        ret_illegal_nxt = land_illegal[2];
      end
      default: begin
        // Level three entry
        ret_sec_nxt     = land_state[7:6];
        ret_illegal_nxt = land_illegal[3];
      end
    endcase
  end

  // Registered security state
  // decoded state output
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_sec_state <= `SEC_RST;
    end else begin
      o_sec_state <= sec_nxt;
    end
  end

  // Registered reserved encoding flag
  // flag follows the bit pair
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_reserved_enc <= `FLAG_RST;
    end else begin
      o_reserved_enc <= rsvd;
    end
  end

  // Current width fault, not sensed here
  // Kept low for a later width sense
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_cur_width_bad <= `FLAG_RST;
    end else begin
      o_cur_width_bad <= 1'b0;
    end
  end

  // Return done pulse, one cycle after the request
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_ret_done <= `FLAG_RST;
    end else begin
      o_ret_done <= i_ret_valid;
    end
  end

  // Return verdict, held until the next return
  // illegal return flag
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_ret_illegal <= `FLAG_RST;
    end else if (i_ret_valid) begin
      o_ret_illegal <= ret_illegal_nxt;
    end
  end

  // Landing state, held until the next return
  // state after the return
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_ret_sec_state <= `SEC_RST;
    end else if (i_ret_valid) begin
      o_ret_sec_state <= ret_sec_nxt;
    end
  end

endmodule // security_state_decode

// ### core/security_state_map.vh
// Purpose: Constants for the security state decoder
// Assumes: Included by bare name from core design files
// Notes:   Encodings of levels and security states
`ifndef SECURITY_STATE_MAP_VH
`define SECURITY_STATE_MAP_VH

`define LEVEL_W        2
`define LEVEL_ZERO     2'h0
`define LEVEL_ONE      2'h1
`define LEVEL_TWO      2'h2
`define LEVEL_TOP      2'h3
`define SEC_W          2
`define SEC_NONSECURE  2'h0
`define SEC_SECURE     2'h1
`define SEC_REALM      2'h2
`define SEC_ROOT       2'h3
`define SEC_RST        2'h3
`define FLAG_RST       1'b0

`endif

// ### testbench/exc_ctrl_model.sv
// Purpose: Exception control side feeding the decoder
// Assumes: Each call waits for the next rising edge itself
// Notes:   Fields change 1 ns after that edge
`timescale 1ns/1ps
module exc_ctrl_model(
  input  wire logic       i_clk_sys,
  output logic [8:0] o_req);
  initial o_req = 9'h000;
  // Level, target, bit pair, feature, valid, narrow
  task put(input [8:0] v);
    @(posedge i_clk_sys);
    #1 o_req = v;
  endtask
endmodule // exc_ctrl_model

// ### testbench/ssd_monitor.sv
// Purpose: Port assertions of the decoder
// Assumes: Bound to security_state_decode
// Notes:   Outputs lag inputs one cycle
`timescale 1ns/1ps
module ssd_mon(
  input wire logic i_clk_sys, i_rst, i_ext_nonsecure_bit, i_nonsecure_bit,
  input wire logic i_realm_feature_flag, i_ret_valid, i_ret_narrow,
  input wire logic o_reserved_enc, o_ret_done, o_ret_illegal,
  input wire logic [1:0] i_cur_level, i_ret_level, o_sec_state, o_ret_sec_state);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Reserved pair and level below top
  wire ef = i_realm_feature_flag & i_ext_nonsecure_bit;
  wire rsv = ef & ~i_nonsecure_bit;
  wire low = i_cur_level != 2'h3;
  chk_top_root: assert property (!low |=> o_sec_state == 2'h3)
    else $error("top level not root");
  chk_secure_dec: assert property (low && !ef && !i_nonsecure_bit |=> o_sec_state == 2'h1)
    else $error("secure decode wrong");
  chk_realm_dec: assert property (low && ef && i_nonsecure_bit |=> o_sec_state == 2'h2)
    else $error("realm decode wrong");
  chk_nonsec_dec: assert property (low && !ef && i_nonsecure_bit |=> o_sec_state == 2'h0)
    else $error("non-secure decode wrong");
  chk_ret_top: assert property (
    i_ret_valid && i_ret_level == 2'h3 |=> o_ret_sec_state == 2'h3)
    else $error("return to top not root");
  chk_narrow_bad: assert property (
    i_ret_valid && i_ret_narrow && i_ret_level != 2'h0 |=> o_ret_illegal)
    else $error("narrow return allowed");
  chk_illegal_ret: assert property (
    i_ret_valid && !low && i_ret_level != 2'h3 && rsv |=> o_ret_illegal)
    else $error("reserved return allowed");
  chk_ret_pulse: assert property (1 |=> o_ret_done == $past(i_ret_valid))
    else $error("done pulse wrong");
  chk_enc_flag: assert property (1 |=> o_reserved_enc == $past(rsv))
    else $error("reserved flag wrong");
endmodule // ssd_mon
bind security_state_decode ssd_mon chk_u(
  .i_clk_sys, .i_rst, .i_ext_nonsecure_bit, .i_nonsecure_bit, .i_realm_feature_flag,
  .i_ret_valid, .i_ret_narrow, .o_reserved_enc, .o_ret_done, .o_ret_illegal,
  .i_cur_level, .i_ret_level, .o_sec_state, .o_ret_sec_state);

// ### testbench/testbench.sv
// Purpose: Self-checking bench of the decoder
// Assumes: Outputs follow inputs one cycle later
// Notes:   Sweeps levels, bit pairs, feature and width
`timescale 1ns/1ps
`include "security_state_map.vh"
`define CMP(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
  $display("Error %0t got %h exp %h", $time, a, b); end end
module testbench;
  logic i_clk_sys = 0, i_rst = 1, er, ed, ei, rs, wb, dn, il;
  logic [8:0] q, v;
  logic [5:0] kk;
  logic [1:0] sec, rsec, es, ers;
  int errors = 0, checks_done = 0;
  exc_ctrl_model pm(.i_clk_sys, .o_req(q));
  security_state_decode dut_u(.i_clk_sys, .i_rst, .i_cur_level(q[8:7]), .i_ret_level(q[6:5]),
    .i_ext_nonsecure_bit(q[4]), .i_nonsecure_bit(q[3]), .i_realm_feature_flag(q[2]),
    .i_ret_valid(q[1]), .i_ret_narrow(q[0]), .o_sec_state(sec), .o_reserved_enc(rs),
    .o_cur_width_bad(wb), .o_ret_done(dn), .o_ret_illegal(il), .o_ret_sec_state(rsec));
  // Expected state from level and bit pair
  function logic [1:0] st(input [1:0] l, input x, y);
    return l == `LEVEL_TOP ? `SEC_ROOT : {x, y} == 2'h1 ? `SEC_NONSECURE :
      {x, y} == 2'h3 ? `SEC_REALM : `SEC_SECURE;
  endfunction
  // Outputs at their reset values
  task chk_rst;
    `CMP({sec, rsec}, {`SEC_RST, `SEC_RST});
    `CMP({rs, wb, dn, il}, 4'h0);
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial forever #20 i_clk_sys = ~i_clk_sys;
  // Reset values, then back-to-back returns, one request per cycle
  initial begin
    repeat (2) @(posedge i_clk_sys);
    #1 chk_rst();
    i_rst = 0;
    for (int k = 0; k <= 69; k++) begin
      kk = k[5:0];
      v = k == 64 ? 9'h066 : k == 65 ? 9'h1f6 : k == 66 ? 9'h1df : k == 67 ? 9'h0c8 :
        k > 67 ? 9'h000 :
        {kk[1:0], (&kk[1:0]) ? 2'h1 : 2'h0, kk[2], kk[3], kk[4], 1'b1, kk[5]};
      pm.put(v);
      if (k > 0) begin
        `CMP(sec, es);
        `CMP(rs, er);
        `CMP({dn, il, rsec}, {ed, ei, ers});
        `CMP(wb, 1'b0);
      end
      es = st(v[8:7], v[4] & v[2], v[3]);
      er = v[4] & ~v[3] & v[2];
      ed = v[1];
      if (v[1]) ei = (v[0] && v[6:5] != `LEVEL_ZERO) ||
        (v[8:7] == `LEVEL_TOP && v[6:5] != `LEVEL_TOP && er);
      if (v[1]) ers = st(v[6:5], v[4] & v[2], v[3]);
    end
    $display("sweep test done");
    // Reset in mid-run, then an illegal return from the top level
    @(posedge i_clk_sys) #1 i_rst = 1;
    #1 chk_rst();
    @(posedge i_clk_sys) #1 i_rst = 0;
    chk_rst();
    pm.put(9'h1d6);
    @(posedge i_clk_sys) #1;
    `CMP({sec, rs, dn, il, rsec}, {`SEC_ROOT, 3'h7, `SEC_SECURE});
    $display("reset test done");
    report_and_stop();
  end
endmodule // testbench
